// ==== shared/irq_wdt_pkg.sv ====
// Constants and carrier types for the interrupt, watchdog and comparator control
package irq_wdt_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [4:0] OFS_FLAG    = 5'h00;
	localparam logic [4:0] OFS_ENABLE  = 5'h04;
	localparam logic [4:0] OFS_POWER   = 5'h08;
	localparam logic [4:0] OFS_CMPCTL  = 5'h0c;
	localparam logic [4:0] OFS_OSCSTAT = 5'h10;
	localparam logic [4:0] OFS_STATUS  = 5'h14;
	localparam logic [4:0] OFS_PRESC   = 5'h18;
	localparam logic [4:0] OFS_CONFIG  = 5'h1c;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POWER_WDT_RUN  = 7;
	localparam int POWER_CMP_EN   = 2;
	localparam int OSC_RESULT     = 7;
	localparam int OSC_PIN_OE     = 6;
	localparam int STATUS_TIMEOUT = 4;
	localparam int PRESC_ASSIGN   = 3;
	localparam int CFG_WDT_EN     = 0;
	localparam int CFG_WDT_IRQ    = 1;
	localparam int CFG_PERIOD_LO  = 2;
	localparam int IRQ_COUNT      = 12;
	localparam int IRQ_WDT_BIT    = 6;
	localparam int IRQ_CMP_BIT    = 11;

	// ----------------------------------------
	// Reset values and vector addresses
	// ----------------------------------------
	localparam logic [7:0]  POWER_RST  = 8'h80;
	localparam logic [7:0]  STATUS_RST = 8'h10;
	localparam logic [7:0]  CONFIG_RST = 8'h01;
	localparam logic [10:0] VEC_SW     = 11'h001;
	localparam logic [10:0] VEC_HW     = 11'h008;

	// ----------------------------------------
	// Watchdog timing: periods in microseconds, counts in oscillator ticks
	// ----------------------------------------
	localparam int WDT_OSC_KHZ = 16;
	localparam int WDT_P0_US   = 3500;
	localparam int WDT_P1_US   = 15000;
	localparam int WDT_P2_US   = 60000;
	localparam int WDT_P3_US   = 250000;
	localparam logic [11:0] WDT_CNT_P0 = 12'(WDT_P0_US * WDT_OSC_KHZ / 1000);
	localparam logic [11:0] WDT_CNT_P1 = 12'(WDT_P1_US * WDT_OSC_KHZ / 1000);
	localparam logic [11:0] WDT_CNT_P2 = 12'(WDT_P2_US * WDT_OSC_KHZ / 1000);
	localparam logic [11:0] WDT_CNT_P3 = 12'(WDT_P3_US * WDT_OSC_KHZ / 1000);

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic sw_int;
		logic enable_irq_instr;
		logic disable_irq_instr;
		logic return_from_irq_instr;
		logic watchdog_clear_instr;
	} core_instr_t;

	typedef struct packed {
		logic       valid;
		logic       port_b;
		logic [2:0] idx;
	} pad_t;

	typedef struct packed {
		logic       active;
		logic       pad_to_reference_mode;
		logic [3:0] ref_n;
		pad_t       noninv;
		pad_t       inv;
	} cmp_route_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

endpackage : irq_wdt_pkg

// ==== hdl/sync2.sv ====
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ns
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else if (ce)
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : sync2

// ==== hdl/irq_wdt_comparator_ctrl.sv ====
// Interrupt controller with watchdog and comparator control
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module irq_wdt_comparator_ctrl (
	input  wire logic                     sys_clk,
	input  wire logic                     resetn,
	input  wire logic                     ce,
	input  wire logic [4:0]               avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	input  wire logic [3:0]               avs_byteenable,
	output logic      [31:0]              avs_readdata,
	output logic                          avs_waitrequest,
	input  wire irq_wdt_pkg::core_instr_t core_instr,
	input  wire logic                     halt_mode,
	input  wire logic [11:0]              hw_event,
	input  wire logic                     cmp_raw,
	input  wire logic                     wdt_osc,
	output logic                          vec_valid,
	output logic      [10:0]              vec_addr,
	output logic                          global_irq_enable,
	output logic                          wdt_reset,
	output irq_wdt_pkg::cmp_route_t       cmp_route,
	output logic                          port_b_pin_3_out,
	output logic                          port_b_pin_3_oe,
	output logic                          first_pwm_channel_disable
);

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [1:0] sync_vec;
	logic       cmp_sync;
	logic       osc_sync;
	logic       osc_prev_reg;
	logic       osc_tick;

	sync2 #(.W(2)) u_sync (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.ce       (ce),
		.async_in ({cmp_raw, wdt_osc}),
		.sync_out (sync_vec)
	);
	assign cmp_sync = sync_vec[1];
	assign osc_sync = sync_vec[0];
	assign osc_tick = osc_sync & ~osc_prev_reg;

	// ----------------------------------------
	// Bus slave and registers
	// ----------------------------------------
	irq_wdt_pkg::bus_state_t bus_reg, bus_next;
	logic [11:0] flag_reg, flag_next, ien_reg, ien_next;
	logic [7:0]  power_reg, power_next, cmpctl_reg, cmpctl_next;
	logic [7:0]  status_reg, status_next, presc_reg, presc_next, config_reg, config_next;
	logic        oe_reg, oe_next, copy_reg, copy_next;
	logic [31:0] rdata_next;
	logic        wr_go, rd_go;
	logic        wdt_expire, clr_wdt;
	logic [11:0] set_vec;

	assign wr_go = (bus_reg == irq_wdt_pkg::BUS_ACK) && avs_write && avs_byteenable[0];
	assign rd_go = (bus_reg == irq_wdt_pkg::BUS_ACK) && avs_read;
	assign clr_wdt = core_instr.watchdog_clear_instr;

	always_comb
	begin
		set_vec = hw_event;
		set_vec[irq_wdt_pkg::IRQ_WDT_BIT] = wdt_expire & config_reg[irq_wdt_pkg::CFG_WDT_IRQ];
		set_vec[irq_wdt_pkg::IRQ_CMP_BIT] = cmp_route.active & (cmp_sync != copy_reg);
		bus_next = irq_wdt_pkg::BUS_IDLE;
		if (bus_reg == irq_wdt_pkg::BUS_IDLE && (avs_read || avs_write))
			bus_next = irq_wdt_pkg::BUS_ACK;
		flag_next = flag_reg;
		ien_next = ien_reg;
		power_next = power_reg;
		cmpctl_next = cmpctl_reg;
		oe_next = oe_reg;
		presc_next = presc_reg;
		config_next = config_reg;
		status_next = status_reg;
		copy_next = copy_reg;
		if (wr_go)
		begin
			case (avs_address)
				irq_wdt_pkg::OFS_FLAG:    flag_next = flag_reg & avs_writedata[11:0];
				irq_wdt_pkg::OFS_ENABLE:  ien_next = avs_writedata[11:0];
				irq_wdt_pkg::OFS_POWER:   power_next = avs_writedata[7:0];
				irq_wdt_pkg::OFS_CMPCTL:  cmpctl_next = avs_writedata[7:0];
				irq_wdt_pkg::OFS_OSCSTAT: oe_next = avs_writedata[irq_wdt_pkg::OSC_PIN_OE];
				irq_wdt_pkg::OFS_PRESC:   presc_next = {4'h0, avs_writedata[3:0]};
				irq_wdt_pkg::OFS_CONFIG:  config_next = {4'h0, avs_writedata[3:0]};
				default:                  flag_next = flag_reg;
			endcase
		end
		flag_next = flag_next | set_vec;
		if (rd_go && avs_address == irq_wdt_pkg::OFS_OSCSTAT)
			copy_next = cmp_sync;
		if (clr_wdt)
			status_next[irq_wdt_pkg::STATUS_TIMEOUT] = 1'b1;
		else if (wdt_expire)
			status_next[irq_wdt_pkg::STATUS_TIMEOUT] = 1'b0;
		rdata_next = avs_readdata;
		if (bus_next == irq_wdt_pkg::BUS_ACK)
		begin
			case (avs_address)
				irq_wdt_pkg::OFS_FLAG:    rdata_next = {20'h0, flag_reg & ien_reg};
				irq_wdt_pkg::OFS_ENABLE:  rdata_next = {20'h0, ien_reg};
				irq_wdt_pkg::OFS_POWER:   rdata_next = {24'h0, power_reg};
				irq_wdt_pkg::OFS_CMPCTL:  rdata_next = {24'h0, cmpctl_reg};
				irq_wdt_pkg::OFS_OSCSTAT: rdata_next = {24'h0, cmp_sync, oe_reg, 6'h0};
				irq_wdt_pkg::OFS_STATUS:  rdata_next = {24'h0, status_reg};
				irq_wdt_pkg::OFS_PRESC:   rdata_next = {24'h0, presc_reg};
				irq_wdt_pkg::OFS_CONFIG:  rdata_next = {24'h0, config_reg};
				default:                  rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bus_reg <= irq_wdt_pkg::BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
			flag_reg <= 12'h0;
			ien_reg <= 12'h0;
			power_reg <= irq_wdt_pkg::POWER_RST;
			cmpctl_reg <= 8'h00;
			oe_reg <= 1'b0;
			presc_reg <= 8'h00;
			config_reg <= irq_wdt_pkg::CONFIG_RST;
			status_reg <= irq_wdt_pkg::STATUS_RST;
			copy_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end
		else if (ce)
		begin
			bus_reg <= bus_next;
			avs_waitrequest <= (bus_next != irq_wdt_pkg::BUS_ACK);
			avs_readdata <= rdata_next;
			flag_reg <= flag_next;
			ien_reg <= ien_next;
			power_reg <= power_next;
			cmpctl_reg <= cmpctl_next;
			oe_reg <= oe_next;
			presc_reg <= presc_next;
			config_reg <= config_next;
			status_reg <= status_next;
			copy_reg <= copy_next;
			osc_prev_reg <= osc_sync;
		end
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	logic [11:0] wdt_cnt_reg, wdt_cnt_next, wdt_limit;
	logic [7:0]  pre_cnt_reg, pre_cnt_next, pre_limit;
	logic        wdt_run;
	logic        base_end;

	assign wdt_run = config_reg[irq_wdt_pkg::CFG_WDT_EN] & power_reg[irq_wdt_pkg::POWER_WDT_RUN];

	always_comb
	begin
		case (config_reg[irq_wdt_pkg::CFG_PERIOD_LO +: 2])
			2'b00:   wdt_limit = irq_wdt_pkg::WDT_CNT_P0;
			2'b01:   wdt_limit = irq_wdt_pkg::WDT_CNT_P1;
			2'b10:   wdt_limit = irq_wdt_pkg::WDT_CNT_P2;
			default: wdt_limit = irq_wdt_pkg::WDT_CNT_P3;
		endcase
		pre_limit = 8'h00;
		if (presc_reg[irq_wdt_pkg::PRESC_ASSIGN])
		begin
			pre_limit = 8'((9'h001 << presc_reg[2:0]) - 9'h001);
			if (config_reg[irq_wdt_pkg::CFG_WDT_IRQ])
				pre_limit = 8'((9'h002 << presc_reg[2:0]) - 9'h001);
		end
		base_end = wdt_run && osc_tick && (wdt_cnt_reg == wdt_limit - 12'h001);
		wdt_expire = base_end && (pre_cnt_reg == pre_limit);
		wdt_cnt_next = wdt_cnt_reg;
		pre_cnt_next = pre_cnt_reg;
		if (clr_wdt)
		begin
			wdt_cnt_next = 12'h000;
			pre_cnt_next = 8'h00;
		end
		else if (wdt_run && osc_tick)
		begin
			wdt_cnt_next = base_end ? 12'h000 : wdt_cnt_reg + 12'h001;
			if (base_end)
				pre_cnt_next = wdt_expire ? 8'h00 : pre_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wdt_cnt_reg <= 12'h000;
			pre_cnt_reg <= 8'h00;
			wdt_reset <= 1'b0;
		end
		else if (ce)
		begin
			wdt_cnt_reg <= wdt_cnt_next;
			pre_cnt_reg <= pre_cnt_next;
			wdt_reset <= wdt_expire & ~config_reg[irq_wdt_pkg::CFG_WDT_IRQ];
		end
	end

	// ----------------------------------------
	// Global enable and vectoring
	// ----------------------------------------
	logic gie_next, vec_valid_next;
	logic [10:0] vec_addr_next;
	logic hw_pending;

	assign hw_pending = |(flag_reg & ien_reg);

	always_comb
	begin
		gie_next = global_irq_enable;
		vec_valid_next = 1'b0;
		vec_addr_next = vec_addr;
		if (core_instr.enable_irq_instr || core_instr.return_from_irq_instr)
			gie_next = 1'b1;
		else if (core_instr.disable_irq_instr)
			gie_next = 1'b0;
		if (core_instr.sw_int)
		begin
			vec_valid_next = 1'b1;
			vec_addr_next = irq_wdt_pkg::VEC_SW;
			gie_next = 1'b0;
		end
		else if (hw_pending && global_irq_enable && !vec_valid)
		begin
			vec_valid_next = 1'b1;
			vec_addr_next = irq_wdt_pkg::VEC_HW;
			gie_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			global_irq_enable <= 1'b0;
			vec_valid <= 1'b0;
			vec_addr <= 11'h000;
		end
		else if (ce)
		begin
			global_irq_enable <= gie_next;
			vec_valid <= vec_valid_next;
			vec_addr <= vec_addr_next;
		end
	end

	// ----------------------------------------
	// Comparator routing
	// ----------------------------------------
	irq_wdt_pkg::cmp_route_t route_next;
	logic [3:0] pad_sel;

	assign pad_sel = cmpctl_reg[7:4];

	always_comb
	begin
		route_next.active = power_reg[irq_wdt_pkg::POWER_CMP_EN] & ~halt_mode;
		route_next.pad_to_reference_mode = (cmpctl_reg[3:0] != 4'h0);
		route_next.ref_n = cmpctl_reg[3:0];
		route_next.noninv = '0;
		route_next.inv = '0;
		if (route_next.pad_to_reference_mode)
		begin
			route_next.noninv.valid = (pad_sel != 4'h5) && (pad_sel[3:1] != 3'h7);
			route_next.noninv.port_b = pad_sel[3];
			route_next.noninv.idx = pad_sel[2:0];
		end
		else
		begin
			route_next.noninv.valid = 1'b1;
			route_next.inv.valid = 1'b1;
			route_next.noninv.port_b = pad_sel[3];
			route_next.noninv.idx = {pad_sel[3] & pad_sel[1], pad_sel[3] ^ pad_sel[1], pad_sel[0]};
			route_next.inv.port_b = pad_sel[2];
			route_next.inv.idx = {pad_sel[2] & pad_sel[1], pad_sel[2] ^ pad_sel[1], ~pad_sel[0]};
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmp_route <= '0;
			port_b_pin_3_out <= 1'b0;
			port_b_pin_3_oe <= 1'b0;
			first_pwm_channel_disable <= 1'b0;
		end
		else if (ce)
		begin
			cmp_route <= route_next;
			port_b_pin_3_out <= cmp_sync;
			port_b_pin_3_oe <= oe_reg;
			first_pwm_channel_disable <= oe_reg;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_cmp_halt_off: assert property (ce && halt_mode |=> !cmp_route.active)
		else $error("comparator active in halt");
	a_cmp_en_on: assert property (ce && !halt_mode && power_reg[2] |=> cmp_route.active)
		else $error("comparator not active when enabled");
	a_cmp_mode_sel: assert property (ce |=> cmp_route.pad_to_reference_mode
		== ($past(cmpctl_reg[3:0]) != 4'h0))
		else $error("comparator mode wrong");
	a_flag_sticky: assert property (ce && flag_reg[0] && !wr_go |=> flag_reg[0])
		else $error("flag lost without write");
	a_set_over_clr: assert property (ce && hw_event[0] |=> flag_reg[0])
		else $error("event lost");
	a_sw_vector: assert property (ce && core_instr.sw_int |=> vec_valid
		&& vec_addr == 11'h001 && !global_irq_enable)
		else $error("software vector wrong");
	a_hw_vector: assert property (ce && !core_instr.sw_int && hw_pending
		&& global_irq_enable && !vec_valid
		|=> vec_valid && vec_addr == 11'h008 && !global_irq_enable)
		else $error("hardware vector wrong");
	a_no_hw_gie_off: assert property (ce && !global_irq_enable && !core_instr.sw_int
		|=> !vec_valid)
		else $error("vector without global enable");
	a_return_sets: assert property (ce && core_instr.return_from_irq_instr
		&& !core_instr.sw_int && !(hw_pending && global_irq_enable && !vec_valid)
		|=> global_irq_enable)
		else $error("return did not set global enable");
	a_timeout_clear: assert property (ce && wdt_expire && !clr_wdt |=> !status_reg[4])
		else $error("timeout flag not cleared");
	a_wdt_clear: assert property (ce && clr_wdt |=> wdt_cnt_reg == 12'h000
		&& pre_cnt_reg == 8'h00 && status_reg[4])
		else $error("watchdog clear failed");
	a_bus_answer: assert property (ce && bus_reg == irq_wdt_pkg::BUS_IDLE
		&& (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not exactly one cycle");

	c_sw_int: cover property (core_instr.sw_int ##1 vec_valid);
	c_hw_int: cover property (hw_pending && global_irq_enable ##1 vec_valid);
	c_wdt_out: cover property (wdt_expire);
	c_cmp_flag: cover property (set_vec[11]);

endmodule : irq_wdt_comparator_ctrl

// ==== bench/core_model.sv ====
// Model of the processor core and the watchdog oscillator beside the block
`timescale 1ns/1ns
module core_model (
	input  wire logic                sys_clk,
	input  wire logic                vec_valid,
	input  wire logic [10:0]         vec_addr,
	input  wire logic                wdt_reset,
	output irq_wdt_pkg::core_instr_t core_instr,
	output logic                     wdt_osc
);
	logic        osc_run  = 1'b0;
	int          ticks    = 0;
	int          n_vec    = 0;
	int          n_wrst   = 0;
	int          tick_at  = 0;
	logic [10:0] last_vec = 11'h000;

	initial core_instr = '0;
	initial wdt_osc = 1'b0;

	// Oscillator, even half period so it never meets a rising clock edge
	always #42 if (osc_run) wdt_osc = ~wdt_osc;
	always @(posedge wdt_osc) ticks++;

	// Record fetch redirects and watchdog resets
	always @(posedge sys_clk)
	begin
		if (vec_valid === 1'b1)
		begin
			n_vec++;
			last_vec = vec_addr;
			tick_at = ticks;
		end
		if (wdt_reset === 1'b1)
		begin
			n_wrst++;
			tick_at = ticks;
		end
	end

	// One-cycle instruction pulse
	task automatic issue(input irq_wdt_pkg::core_instr_t c);
		@(posedge sys_clk);
		core_instr <= c;
		@(posedge sys_clk);
		core_instr <= '0;
	endtask : issue
endmodule : core_model

// ==== bench/test_irq_wdt_comparator_ctrl.sv ====
// Testbench for the interrupt, watchdog and comparator control block
`timescale 1ns/1ns
module test_irq_wdt_comparator_ctrl;
	localparam irq_wdt_pkg::core_instr_t I_SW  = 5'h10;
	localparam irq_wdt_pkg::core_instr_t I_IRQ_ON = 5'h08;
	localparam irq_wdt_pkg::core_instr_t I_DIS = 5'h04;
	localparam irq_wdt_pkg::core_instr_t I_RET = 5'h02;
	localparam irq_wdt_pkg::core_instr_t I_CLR = 5'h01;
	localparam logic [0:15][7:0] PAIR_TAB = {8'h01, 8'h10, 8'h23, 8'h32, 8'h0b, 8'h1a, 8'h2d,
		8'h3c, 8'ha1, 8'hb0, 8'hc3, 8'hd2, 8'hab, 8'hba, 8'hcd, 8'hdc};

	logic                       sys_clk        = 1'b0;
	logic                       resetn         = 1'b0;
	logic [4:0]                 avs_address    = 5'h00;
	logic                       avs_read       = 1'b0;
	logic                       avs_write      = 1'b0;
	logic [31:0]                avs_writedata  = 32'h0;
	logic [3:0]                 avs_byteenable = 4'h0;
	logic [31:0]                avs_readdata;
	logic                       avs_waitrequest;
	irq_wdt_pkg::core_instr_t   core_instr;
	logic                       halt_mode      = 1'b0;
	logic [11:0]                hw_event       = 12'h000;
	logic                       cmp_raw        = 1'b0;
	logic                       wdt_osc;
	logic                       vec_valid;
	logic [10:0]                vec_addr;
	logic                       global_irq_enable;
	logic                       wdt_reset;
	irq_wdt_pkg::cmp_route_t    cmp_route;
	logic                       port_b_pin_3_out;
	logic                       port_b_pin_3_oe;
	logic                       first_pwm_channel_disable;
	int                         n_errors       = 0;
	int                         check_count    = 0;
	int                         cyc            = 0;

	always #5 sys_clk = ~sys_clk;

	irq_wdt_comparator_ctrl uut (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.core_instr(core_instr), .halt_mode(halt_mode), .hw_event(hw_event),
		.cmp_raw(cmp_raw), .wdt_osc(wdt_osc), .vec_valid(vec_valid), .vec_addr(vec_addr),
		.global_irq_enable(global_irq_enable), .wdt_reset(wdt_reset),
		.cmp_route(cmp_route), .port_b_pin_3_out(port_b_pin_3_out),
		.port_b_pin_3_oe(port_b_pin_3_oe),
		.first_pwm_channel_disable(first_pwm_channel_disable));

	core_model core (.sys_clk(sys_clk), .vec_valid(vec_valid), .vec_addr(vec_addr),
		.wdt_reset(wdt_reset), .core_instr(core_instr), .wdt_osc(wdt_osc));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= rd;
		avs_write <= !rd;
		do
		begin
			@(posedge sys_clk);
		end
		while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		xfer(1'b0, a, d, 4'h1);
	endtask : wr

	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
		xfer(1'b1, a, 32'h0, 4'h1);
		chk(avs_readdata, exp);
	endtask : rdchk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wait_cyc

	task automatic pulse(input logic [11:0] e);
		@(posedge sys_clk);
		hw_event <= e;
		@(posedge sys_clk);
		hw_event <= 12'h000;
	endtask : pulse

	task automatic step(input irq_wdt_pkg::core_instr_t c, input logic g, input int nv,
		input logic [10:0] va);
		core.issue(c);
		wait_cyc(3);
		chk(32'(global_irq_enable), 32'(g));
		chk(core.n_vec, nv);
		chk(32'(core.last_vec), 32'(va));
	endtask : step

	task automatic note(input string s);
		$display("test %s ended, errors %0d", s, n_errors);
	endtask : note

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		int i;
		int v;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		wait_cyc(1);
		chk(32'(cmp_route.active), 32'h0);
		rdchk(irq_wdt_pkg::OFS_POWER, 32'h80);
		rdchk(irq_wdt_pkg::OFS_STATUS, 32'h10);
		rdchk(irq_wdt_pkg::OFS_CONFIG, 32'h01);
		rdchk(5'h02, 32'h0);
		xfer(1'b0, irq_wdt_pkg::OFS_POWER, 32'h84, 4'h0);
		rdchk(irq_wdt_pkg::OFS_POWER, 32'h80);
		note("reset");
		wr(irq_wdt_pkg::OFS_POWER, 32'h84);
		wait_cyc(3);
		chk(32'(cmp_route.active), 32'h1);
		halt_mode <= 1'b1;
		wait_cyc(3);
		chk(32'(cmp_route.active), 32'h0);
		halt_mode <= 1'b0;
		for (i = 0; i < 16; i++)
		begin
			wr(irq_wdt_pkg::OFS_CMPCTL, 32'(i * 16 + i % 15 + 1));
			wait_cyc(3);
			v = (i == 5 || i > 13) ? 0 : 16 + i;
			chk(32'({cmp_route.pad_to_reference_mode, cmp_route.ref_n}),
				32'(16 + i % 15 + 1));
			chk(32'(cmp_route.noninv & ((v == 0) ? 5'h10 : 5'h1f)), 32'(v));
			wr(irq_wdt_pkg::OFS_CMPCTL, 32'(i * 16));
			wait_cyc(3);
			chk(32'({cmp_route.pad_to_reference_mode, cmp_route.noninv, cmp_route.inv}),
				32'({2'b01, PAIR_TAB[i][7:4], 1'b1, PAIR_TAB[i][3:0]}));
		end
		note("routing");
		wr(irq_wdt_pkg::OFS_ENABLE, 32'h800);
		wr(irq_wdt_pkg::OFS_OSCSTAT, 32'h40);
		for (i = 0; i < 2; i++)
		begin
			cmp_raw <= (i == 0);
			wait_cyc(6);
			chk(32'({port_b_pin_3_out, port_b_pin_3_oe, first_pwm_channel_disable}),
				(i == 0) ? 32'h7 : 32'h3);
			rdchk(irq_wdt_pkg::OFS_FLAG, 32'h800);
			rdchk(irq_wdt_pkg::OFS_OSCSTAT, (i == 0) ? 32'hc0 : 32'h40);
			wr(irq_wdt_pkg::OFS_FLAG, 32'h0);
			rdchk(irq_wdt_pkg::OFS_FLAG, 32'h0);
		end
		wr(irq_wdt_pkg::OFS_OSCSTAT, 32'h0);
		wait_cyc(3);
		chk(32'({port_b_pin_3_oe, first_pwm_channel_disable}), 32'h0);
		note("comparator");
		wr(irq_wdt_pkg::OFS_ENABLE, 32'h0);
		pulse(12'h008);
		rdchk(irq_wdt_pkg::OFS_FLAG, 32'h0);
		wr(irq_wdt_pkg::OFS_ENABLE, 32'h008);
		rdchk(irq_wdt_pkg::OFS_FLAG, 32'h008);
		chk(core.n_vec, 0);
		step(I_IRQ_ON, 1'b0, 1, 11'h008);
		wr(irq_wdt_pkg::OFS_FLAG, 32'h0);
		step(I_RET, 1'b1, 1, 11'h008);
		step(I_SW, 1'b0, 2, 11'h001);
		step(I_SW, 1'b0, 3, 11'h001);
		step(I_IRQ_ON, 1'b1, 3, 11'h001);
		step(I_DIS, 1'b0, 3, 11'h001);
		pulse(12'h008);
		wait_cyc(4);
		chk(core.n_vec, 3);
		wr(irq_wdt_pkg::OFS_FLAG, 32'h0);
		note("interrupts");
		wr(irq_wdt_pkg::OFS_POWER, 32'h04);
		core.issue(I_CLR);
		core.ticks = 0;
		core.osc_run = 1'b1;
		for (i = 0; i < 2000 && core.ticks < 70; i++) @(posedge sys_clk);
		core.osc_run = 1'b0;
		chk(core.n_wrst, 0);
		wr(irq_wdt_pkg::OFS_POWER, 32'h84);
		core.issue(I_CLR);
		halt_mode <= 1'b1;
		core.ticks = 0;
		core.osc_run = 1'b1;
		for (i = 0; i < 3000 && core.n_wrst == 0; i++) @(posedge sys_clk);
		core.osc_run = 1'b0;
		halt_mode <= 1'b0;
		wait_cyc(4);
		chk(core.n_wrst, 1);
		chk(core.tick_at, 32'(irq_wdt_pkg::WDT_CNT_P0));
		rdchk(irq_wdt_pkg::OFS_STATUS, 32'h0);
		core.issue(I_CLR);
		rdchk(irq_wdt_pkg::OFS_STATUS, 32'h10);
		wr(irq_wdt_pkg::OFS_CONFIG, 32'h03);
		wr(irq_wdt_pkg::OFS_PRESC, 32'h09);
		wr(irq_wdt_pkg::OFS_ENABLE, 32'h040);
		core.issue(I_CLR);
		core.issue(I_IRQ_ON);
		core.ticks = 0;
		core.osc_run = 1'b1;
		for (i = 0; i < 6000 && core.n_vec == 3; i++) @(posedge sys_clk);
		core.osc_run = 1'b0;
		chk(32'(core.last_vec), 32'h008);
		chk(core.tick_at, 32'(4 * irq_wdt_pkg::WDT_CNT_P0));
		rdchk(irq_wdt_pkg::OFS_FLAG, 32'h040);
		rdchk(irq_wdt_pkg::OFS_STATUS, 32'h0);
		chk(core.n_wrst, 1);
		note("watchdog");
		wrap_up();
	end
endmodule : test_irq_wdt_comparator_ctrl
